// [hw/sltx_pkg.sv]
// Shared constants and types for the serial link transmit control block
package sltx_pkg;

  // Bus geometry
  localparam int unsigned AXI_ADDR_W = 12;
  localparam int unsigned AXI_DATA_W = 32;

  // Register indices as printed; byte address is four times the index
  localparam logic [AXI_ADDR_W-1:0] IDX_TRIG_RESET_MASK_CTRL = 12'h046;
  localparam logic [AXI_ADDR_W-1:0] IDX_LINK_CHAR_CTRL       = 12'h049;
  localparam logic [AXI_ADDR_W-1:0] IDX_FORCED_MF_LENGTH     = 12'h053;
  localparam logic [AXI_ADDR_W-1:0] ADDR_TRIG_RESET_MASK_CTRL = 12'h118;
  localparam logic [AXI_ADDR_W-1:0] ADDR_LINK_CHAR_CTRL       = 12'h124;
  localparam logic [AXI_ADDR_W-1:0] ADDR_FORCED_MF_LENGTH     = 12'h14c;
  localparam logic [AXI_ADDR_W-1:0] ADDR_LINK_STATUS          = 12'h200;

  // Field positions
  localparam int unsigned POS_TRIGGER_RESET_MASK  = 2;
  localparam int unsigned POS_NONLINK_RESET_INHIB = 1;
  localparam int unsigned POS_IDLE_MODE           = 15;
  localparam int unsigned POS_LANE_ALIGN          = 12;
  localparam int unsigned POS_FRAME_ALIGN         = 11;
  localparam int unsigned POS_LANE_ALIGN_SEQ_DIS  = 10;
  localparam int unsigned POS_FORCE_MF_LENGTH     = 2;
  localparam int unsigned POS_STAT_STATE          = 0;
  localparam int unsigned POS_STAT_K              = 2;
  localparam int unsigned POS_STAT_IDLE           = 8;

  // Reset values
  localparam logic        RST_BIT       = 1'b0;
  localparam logic [4:0]  RST_FORCED_K  = 5'h00;
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Framing
  localparam logic [3:0] OCTETS_PER_FRAME_M1 = 4'h1;
  localparam logic [4:0] AUTO_MF_LENGTH_M1   = 5'h0f;
  localparam logic [1:0] ILA_LAST_MF         = 2'h3;

  // Characters and patterns
  localparam logic [15:0] IDLE_PATTERN = 16'hbc50;
  localparam logic [7:0]  CHAR_K28_0   = 8'h1c;
  localparam logic [7:0]  CHAR_K28_3   = 8'h7c;
  localparam logic [7:0]  CHAR_K28_5   = 8'hbc;
  localparam logic [7:0]  CHAR_K28_7   = 8'hfc;

  typedef enum logic [1:0] {
    SLTX_CGS  = 2'b00,
    SLTX_ILA  = 2'b01,
    SLTX_DATA = 2'b10
  } sltx_state_t;

endpackage

// [hw/sltx_sync.sv]
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module sltx_sync #(
  parameter int unsigned WIDTH = 3
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Pins and synchronised levels
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);
  import sltx_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sltx_sync_st_t;

  sltx_sync_st_t st;
  sltx_sync_st_t next_st;

  // Stage one feeds stage two only
  always_comb begin
    next_st = st;
    for (int i = 0; i < WIDTH; i++) begin
      next_st.stage1[i] = pinIn[i];
      next_st.stage2[i] = st.stage1[i];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign syncOut = st.stage2;
endmodule

// [hw/sltx_char_replace.sv]
// Frame and multiframe end alignment character replacement, registered output
`timescale 1ns/1ps
module sltx_char_replace (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Controls
  input  wire logic       laneAlignEn,
  input  wire logic       frameAlignEn,
  input  wire logic       bypass,
  input  wire logic       restart,
  // Octet stream in
  input  wire logic [7:0] inOctet,
  input  wire logic       inK,
  input  wire logic       frameEnd,
  input  wire logic       mfEnd,
  // Octet stream out
  output logic      [7:0] outOctet,
  output logic            outK
);
  import sltx_pkg::*;

  typedef struct packed {
    logic [7:0] prevFrameLast;
    logic [7:0] prevMfLast;
    logic       ctrlThis;
    logic       ctrlPrev;
    logic [7:0] outOctet;
    logic       outK;
  } sltx_rep_st_t;

  sltx_rep_st_t st;
  sltx_rep_st_t next_st;
  logic         repMf;
  logic         repFr;
  logic         ctrlNow;

  always_comb begin
    next_st = st;
    repMf   = !bypass && laneAlignEn && mfEnd && !inK && (inOctet == st.prevMfLast);
    repFr   = !bypass && frameAlignEn && frameEnd && !inK && !repMf && !st.ctrlPrev
              && (inOctet == st.prevFrameLast);
    ctrlNow = repMf || repFr || inK;
    if (repMf) begin
      next_st.outOctet = CHAR_K28_3;
      next_st.outK     = 1'b1;
    end else if (repFr) begin
      next_st.outOctet = CHAR_K28_7;
      next_st.outK     = 1'b1;
    end else begin
      next_st.outOctet = inOctet;
      next_st.outK     = inK;
    end
    // Fresh history after alignment phases: no frame replacement in first frame
    if (restart) begin
      next_st.prevFrameLast = 8'h00;
      next_st.prevMfLast    = 8'h00;
      next_st.ctrlThis      = 1'b0;
      next_st.ctrlPrev      = 1'b1;
    end else if (!bypass) begin
      if (frameEnd) begin
        // History keeps the original octet, not the substitute
        next_st.prevFrameLast = inOctet;
        next_st.ctrlPrev      = st.ctrlThis || ctrlNow;
        next_st.ctrlThis      = 1'b0;
        if (mfEnd) begin
          next_st.prevMfLast = inOctet;
        end
      end else begin
        next_st.ctrlThis = st.ctrlThis || ctrlNow;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign outOctet = st.outOctet;
  assign outK     = st.outK;

  property p_mf_replace;
    @(posedge clk) disable iff (!nrst)
    (!bypass && !restart && laneAlignEn && mfEnd && !inK && inOctet == st.prevMfLast)
      |=> (outK && outOctet == CHAR_K28_3);
  endproperty
  a_mf_replace: assert property (p_mf_replace) else $error("mf end not replaced");

  property p_mf_off;
    @(posedge clk) disable iff (!nrst)
    (!bypass && !laneAlignEn && !inK) |=> !(outK && outOctet == CHAR_K28_3);
  endproperty
  a_mf_off: assert property (p_mf_off) else $error("lane align char while disabled");

  property p_fr_replace;
    @(posedge clk) disable iff (!nrst)
    (!bypass && frameAlignEn && frameEnd && !mfEnd && !inK && !st.ctrlPrev && inOctet == st.prevFrameLast)
      |=> (outK && outOctet == CHAR_K28_7);
  endproperty
  a_fr_replace: assert property (p_fr_replace) else $error("frame end not replaced");

  property p_fr_skip;
    @(posedge clk) disable iff (!nrst)
    (st.ctrlPrev && !inK) |=> !(outK && outOctet == CHAR_K28_7);
  endproperty
  a_fr_skip: assert property (p_fr_skip) else $error("frame char after control frame");

  property p_fr_off;
    @(posedge clk) disable iff (!nrst)
    (!bypass && !frameAlignEn && !inK) |=> !(outK && outOctet == CHAR_K28_7);
  endproperty
  a_fr_off: assert property (p_fr_off) else $error("frame align char while disabled");
endmodule

// [hw/sltx_top.sv]
// Transmit link control: registers, link phases, idle pattern and phase resets
//
// Contract
// - A set trigger mask keeps the transmit trigger from causing clock-phase resets; clear, it causes them.
// - A clear reset-inhibit lets SYNC~ and SYSREF events reset the non-link blocks; set, they leave them alone.
// - Idle mode sends the fixed 16-bit pattern continuously on the lane instead of payload.
// - With lane alignment on, a multiframe-end octet equal to the previous one becomes K28.3.
// - With lane alignment off, multiframe-end octets pass unchanged and K28.3 is inserted only in the lane alignment sequence; frame alignment can give K28.7.
// - With frame alignment on, a frame-end octet equal to the previous one becomes K28.7.
// - Frame-end replacement is skipped when a control character went out in the previous frame.
// - With frame alignment off, frame-end octets pass unchanged and K28.7 is never inserted; lane alignment can still give K28.3 at multiframe ends.
// - With the alignment-sequence disable clear, the lane alignment sequence follows code group sync.
// - With the disable set, payload starts right after code group sync.
// - Without override the frames-per-multiframe minus one value is computed internally.
// - With override it is taken from the forced-length field.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sltx_top (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           nrst,
  // AXI4-Lite write address
  input  wire logic [sltx_pkg::AXI_ADDR_W-1:0] awaddr,
  input  wire logic                           awvalid,
  output logic                                awready,
  // AXI4-Lite write data
  input  wire logic [sltx_pkg::AXI_DATA_W-1:0] wdata,
  input  wire logic [3:0]                     wstrb,
  input  wire logic                           wvalid,
  output logic                                wready,
  // AXI4-Lite write response
  output logic      [1:0]                     bresp,
  output logic                                bvalid,
  input  wire logic                           bready,
  // AXI4-Lite read address
  input  wire logic [sltx_pkg::AXI_ADDR_W-1:0] araddr,
  input  wire logic                           arvalid,
  output logic                                arready,
  // AXI4-Lite read data
  output logic      [sltx_pkg::AXI_DATA_W-1:0] rdata,
  output logic      [1:0]                     rresp,
  output logic                                rvalid,
  input  wire logic                           rready,
  // Link pins
  input  wire logic                           syncN,
  input  wire logic                           sysref,
  input  wire logic                           transmitTriggerInput,
  // Payload in
  input  wire logic [7:0]                     payloadOctet,
  output logic                                payloadTaken,
  // Lane out
  output logic      [7:0]                     laneOctet,
  output logic                                laneIsK,
  // Phase resets to other blocks
  output logic                                clkPhaseReset,
  output logic                                nonlinkReset
);
  import sltx_pkg::*;

  typedef struct packed {
    logic                  awHeld;
    logic [AXI_ADDR_W-1:0] awAddr;
    logic                  wHeld;
    logic [AXI_DATA_W-1:0] wData;
    logic [3:0]            wStrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0]            rresp;
    logic                  trigMask;
    logic                  nlInhibit;
    logic                  idleMode;
    logic                  laneAlign;
    logic                  frameAlign;
    logic                  ilaDisable;
    logic                  forceK;
    logic [4:0]            forcedK;
    sltx_state_t           state;
    logic [3:0]            octCnt;
    logic [4:0]            frmCnt;
    logic [1:0]            ilaMf;
    logic                  idlePhase;
    logic                  trigPrev;
    logic                  sysrefPrev;
    logic                  syncPrev;
    logic                  clkPhaseReset;
    logic                  nonlinkReset;
    logic                  payloadTaken;
  } sltx_top_st_t;

  sltx_top_st_t st;
  sltx_top_st_t next_st;

  logic [2:0]  pinSync;
  logic        syncS;
  logic        sysrefS;
  logic        trigS;
  logic        trigEvent;
  logic        linkEvent;
  logic        sysrefEvent;
  logic [4:0]  kEff;
  logic        frameEnd;
  logic        mfEnd;
  logic [7:0]  feedOctet;
  logic        feedK;
  logic        feedBypass;
  logic        feedRestart;
  logic        doWrite;
  logic        wrHit;
  logic        arTake;
  logic [31:0] wrMask;

  sltx_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk     (clk),
    .nrst    (nrst),
    .pinIn   ({transmitTriggerInput, sysref, syncN}),
    .syncOut (pinSync)
  );

  assign syncS   = pinSync[0];
  assign sysrefS = pinSync[1];
  assign trigS   = pinSync[2];

  // Events from synchronised levels
  assign trigEvent   = trigS && !st.trigPrev;
  assign sysrefEvent = sysrefS && !st.sysrefPrev;
  assign linkEvent   = sysrefEvent || (!syncS && st.syncPrev);

  assign kEff     = st.forceK ? st.forcedK : AUTO_MF_LENGTH_M1;
  assign frameEnd = (st.octCnt == OCTETS_PER_FRAME_M1);
  assign mfEnd    = frameEnd && (st.frmCnt == kEff);

  // Lane feed; idle overrides every link phase
  always_comb begin
    feedOctet   = payloadOctet;
    feedK       = 1'b0;
    feedBypass  = 1'b0;
    feedRestart = 1'b0;
    if (st.idleMode) begin
      feedOctet   = st.idlePhase ? IDLE_PATTERN[7:0] : IDLE_PATTERN[15:8];
      feedBypass  = 1'b1;
      feedRestart = 1'b1;
    end else if (st.state == SLTX_CGS) begin
      feedOctet   = CHAR_K28_5;
      feedK       = 1'b1;
      feedBypass  = 1'b1;
      feedRestart = 1'b1;
    end else if (st.state == SLTX_ILA) begin
      feedBypass  = 1'b1;
      feedRestart = 1'b1;
      if (mfEnd) begin
        feedOctet = CHAR_K28_3;
        feedK     = 1'b1;
      end else if (st.octCnt == 4'h0 && st.frmCnt == 5'h00) begin
        feedOctet = CHAR_K28_0;
        feedK     = 1'b1;
      end else begin
        feedOctet = {st.frmCnt[3:0], st.octCnt};
      end
    end
  end

  sltx_char_replace u_rep (
    .clk          (clk),
    .nrst         (nrst),
    .laneAlignEn  (st.laneAlign),
    .frameAlignEn (st.frameAlign),
    .bypass       (feedBypass),
    .restart      (feedRestart),
    .inOctet      (feedOctet),
    .inK          (feedK),
    .frameEnd     (frameEnd),
    .mfEnd        (mfEnd),
    .outOctet     (laneOctet),
    .outK         (laneIsK)
  );

  assign doWrite = st.awHeld && st.wHeld && !st.bvalid;
  assign arTake  = arvalid && !st.rvalid;
  assign wrHit   = (st.awAddr == ADDR_TRIG_RESET_MASK_CTRL) || (st.awAddr == ADDR_LINK_CHAR_CTRL)
                   || (st.awAddr == ADDR_FORCED_MF_LENGTH);
  assign wrMask  = {{16{1'b0}}, {8{st.wStrb[1]}}, {8{st.wStrb[0]}}};

  always_comb begin
    next_st = st;
    // Write channels taken in either order
    if (awvalid && !st.awHeld && !st.bvalid) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = {awaddr[AXI_ADDR_W-1:2], 2'b00};
    end
    if (wvalid && !st.wHeld && !st.bvalid) begin
      next_st.wHeld = 1'b1;
      next_st.wData = wdata;
      next_st.wStrb = wstrb;
    end
    if (doWrite) begin
      next_st.awHeld = 1'b0;
      next_st.wHeld  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = wrHit ? RESP_OKAY : RESP_SLVERR;
      if (st.awAddr == ADDR_TRIG_RESET_MASK_CTRL) begin
        if (wrMask[POS_TRIGGER_RESET_MASK]) begin
          next_st.trigMask = st.wData[POS_TRIGGER_RESET_MASK];
        end
        if (wrMask[POS_NONLINK_RESET_INHIB]) begin
          next_st.nlInhibit = st.wData[POS_NONLINK_RESET_INHIB];
        end
      end else if (st.awAddr == ADDR_LINK_CHAR_CTRL) begin
        if (wrMask[POS_IDLE_MODE]) begin
          next_st.idleMode   = st.wData[POS_IDLE_MODE];
          next_st.laneAlign  = st.wData[POS_LANE_ALIGN];
          next_st.frameAlign = st.wData[POS_FRAME_ALIGN];
          next_st.ilaDisable = st.wData[POS_LANE_ALIGN_SEQ_DIS];
        end
        if (wrMask[POS_FORCE_MF_LENGTH]) begin
          next_st.forceK = st.wData[POS_FORCE_MF_LENGTH];
        end
      end else if (st.awAddr == ADDR_FORCED_MF_LENGTH) begin
        if (wrMask[0]) begin
          next_st.forcedK = st.wData[4:0];
        end
      end
    end else if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    // Read: one cycle to answer
    if (arTake) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = RESP_OKAY;
      next_st.rdata  = RST_WORD;
      if ({araddr[AXI_ADDR_W-1:2], 2'b00} == ADDR_TRIG_RESET_MASK_CTRL) begin
        next_st.rdata[POS_TRIGGER_RESET_MASK]  = st.trigMask;
        next_st.rdata[POS_NONLINK_RESET_INHIB] = st.nlInhibit;
      end else if ({araddr[AXI_ADDR_W-1:2], 2'b00} == ADDR_LINK_CHAR_CTRL) begin
        next_st.rdata[POS_IDLE_MODE]          = st.idleMode;
        next_st.rdata[POS_LANE_ALIGN]         = st.laneAlign;
        next_st.rdata[POS_FRAME_ALIGN]        = st.frameAlign;
        next_st.rdata[POS_LANE_ALIGN_SEQ_DIS] = st.ilaDisable;
        next_st.rdata[POS_FORCE_MF_LENGTH]    = st.forceK;
      end else if ({araddr[AXI_ADDR_W-1:2], 2'b00} == ADDR_FORCED_MF_LENGTH) begin
        next_st.rdata[4:0] = st.forcedK;
      end else if ({araddr[AXI_ADDR_W-1:2], 2'b00} == ADDR_LINK_STATUS) begin
        next_st.rdata[POS_STAT_STATE+1:POS_STAT_STATE] = st.state;
        next_st.rdata[POS_STAT_K+4:POS_STAT_K]         = kEff;
        next_st.rdata[POS_STAT_IDLE]                   = st.idleMode;
      end else begin
        next_st.rresp = RESP_SLVERR;
      end
    end else if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    // Phase resets, one-cycle pulses
    next_st.trigPrev      = trigS;
    next_st.sysrefPrev    = sysrefS;
    next_st.syncPrev      = syncS;
    next_st.clkPhaseReset = trigEvent && !st.trigMask;
    next_st.nonlinkReset  = linkEvent && !st.nlInhibit;
    // Frame and multiframe counters; SYSREF realigns them
    if (sysrefEvent) begin
      next_st.octCnt = 4'h0;
      next_st.frmCnt = 5'h00;
    end else if (mfEnd) begin
      next_st.octCnt = 4'h0;
      next_st.frmCnt = 5'h00;
    end else if (frameEnd) begin
      next_st.octCnt = 4'h0;
      next_st.frmCnt = st.frmCnt + 5'h01;
    end else begin
      next_st.octCnt = st.octCnt + 4'h1;
    end
    next_st.idlePhase = st.idleMode ? !st.idlePhase : 1'b0;
    // Link phases; a low sync request always restarts code group sync
    if (!syncS) begin
      next_st.state = SLTX_CGS;
      next_st.ilaMf = 2'h0;
    end else begin
      case (st.state)
        SLTX_CGS: begin
          if (mfEnd) begin
            next_st.state = st.ilaDisable ? SLTX_DATA : SLTX_ILA;
            next_st.ilaMf = 2'h0;
          end
        end
        SLTX_ILA: begin
          if (mfEnd) begin
            next_st.ilaMf = st.ilaMf + 2'h1;
            if (st.ilaMf == ILA_LAST_MF) begin
              next_st.state = SLTX_DATA;
            end
          end
        end
        SLTX_DATA: begin
          next_st.state = SLTX_DATA;
        end
        default: begin
          next_st.state = SLTX_CGS;
        end
      endcase
    end
    next_st.payloadTaken = (st.state == SLTX_DATA) && !st.idleMode;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign awready       = !st.awHeld && !st.bvalid;
  assign wready        = !st.wHeld && !st.bvalid;
  assign bvalid        = st.bvalid;
  assign bresp         = st.bresp;
  assign arready       = !st.rvalid;
  assign rvalid        = st.rvalid;
  assign rdata         = st.rdata;
  assign rresp         = st.rresp;
  assign payloadTaken  = st.payloadTaken;
  assign clkPhaseReset = st.clkPhaseReset;
  assign nonlinkReset  = st.nonlinkReset;

  sequence s_cgs_leave;
    (st.state == SLTX_CGS) ##1 (st.state != SLTX_CGS);
  endsequence

  sequence s_idle_steady;
    st.idleMode [*3];
  endsequence

  property p_trig_masked;
    @(posedge clk) disable iff (!nrst) (trigEvent && st.trigMask) |=> !clkPhaseReset;
  endproperty
  a_trig_masked: assert property (p_trig_masked) else $error("masked trigger reset phase");

  property p_trig_open;
    @(posedge clk) disable iff (!nrst) (trigEvent && !st.trigMask) |=> clkPhaseReset ##1 !clkPhaseReset;
  endproperty
  a_trig_open: assert property (p_trig_open) else $error("trigger reset pulse wrong");

  property p_nonlink;
    @(posedge clk) disable iff (!nrst) linkEvent |=> (nonlinkReset == !$past(st.nlInhibit));
  endproperty
  a_nonlink: assert property (p_nonlink) else $error("non-link reset mismatch");

  property p_idle_pattern;
    @(posedge clk) disable iff (!nrst)
    s_idle_steady |=> (!laneIsK && laneOctet != $past(laneOctet)
                       && (laneOctet == IDLE_PATTERN[15:8] || laneOctet == IDLE_PATTERN[7:0]));
  endproperty
  a_idle_pattern: assert property (p_idle_pattern) else $error("idle pattern not sent");

  property p_idle_no_payload;
    @(posedge clk) disable iff (!nrst) st.idleMode |=> !payloadTaken;
  endproperty
  a_idle_no_payload: assert property (p_idle_no_payload) else $error("payload taken in idle");

  property p_ila_on;
    @(posedge clk) disable iff (!nrst) (!st.ilaDisable && syncS) ##0 s_cgs_leave |-> st.state == SLTX_ILA;
  endproperty
  a_ila_on: assert property (p_ila_on) else $error("alignment sequence skipped");

  property p_ila_off;
    @(posedge clk) disable iff (!nrst) (st.ilaDisable && syncS) ##0 s_cgs_leave |-> st.state == SLTX_DATA;
  endproperty
  a_ila_off: assert property (p_ila_off) else $error("alignment sequence not skipped");

  property p_k_value;
    @(posedge clk) disable iff (!nrst)
    (frameEnd && !sysrefEvent && st.frmCnt == (st.forceK ? st.forcedK : AUTO_MF_LENGTH_M1)) |=> (st.frmCnt == 5'h00);
  endproperty
  a_k_value: assert property (p_k_value) else $error("multiframe length source wrong");
endmodule

// [tb/sltx_rx_model.sv]
// Link receiver model: requests code group sync, releases it after enough K28.5
`timescale 1ns/1ps
module sltx_rx_model #(
  parameter int NEED = 4
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Lane in, resync request, sync out
  input  wire logic [7:0] laneOctet,
  input  wire logic       laneIsK,
  input  wire logic       resync,
  output logic            syncN = 1'b0
);
  int seen;
  always @(posedge clk) begin
    if (!nrst || resync) begin
      seen <= 0;
      syncN <= 1'b0;
    end else if (laneIsK === 1'b1 && laneOctet === 8'hbc && seen < NEED) seen <= seen + 1;
    else if (seen == NEED) syncN <= 1'b1;
  end
endmodule

// [tb/testbench.sv]
// Bench for the transmit link control block
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin num_errors++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module testbench;
  import sltx_pkg::*;
  logic clk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic sysref = 0, trig = 0, resync = 0, awready, wready, bvalid, arready, rvalid;
  logic payloadTaken, laneIsK, clkPhaseReset, nonlinkReset, syncN;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0] wstrb = 4'hf;
  logic [7:0] payloadOctet = 8'h5a, laneOctet;
  logic [1:0] bresp, rresp, r;
  bit vary = 0;
  int num_errors = 0, checks_done = 0, cyc = 0, nClk = 0, nNl = 0, nK7 = 0, nK3 = 0, nK0 = 0, n0, n1;
  always #4 clk = ~clk;
  sltx_top uut (.clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .syncN(syncN), .sysref(sysref), .transmitTriggerInput(trig),
    .payloadOctet(payloadOctet), .payloadTaken(payloadTaken), .laneOctet(laneOctet), .laneIsK(laneIsK),
    .clkPhaseReset(clkPhaseReset), .nonlinkReset(nonlinkReset));
  sltx_rx_model rx (.clk(clk), .nrst(nrst), .laneOctet(laneOctet), .laneIsK(laneIsK), .resync(resync),
    .syncN(syncN));
  always @(posedge clk) begin
    cyc++;
    if (vary) payloadOctet <= payloadOctet + 8'h01;
    if (clkPhaseReset === 1'b1) nClk++;
    if (nonlinkReset === 1'b1) nNl++;
    if (laneIsK === 1'b1 && laneOctet === CHAR_K28_7) nK7++;
    if (laneIsK === 1'b1 && laneOctet === CHAR_K28_3) nK3++;
    if (laneIsK === 1'b1 && laneOctet === CHAR_K28_0) nK0++;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic ad, dd;
    ad = 0;
    dd = 0;
    @(posedge clk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (!ad && awready === 1'b1) begin ad = 1; awvalid <= 0; end
      if (!dd && wready === 1'b1) begin dd = 1; wvalid <= 0; end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask
  task automatic t_regs();
    rd(ADDR_TRIG_RESET_MASK_CTRL); `CHK("mask reg", RST_WORD, d)
    rd(ADDR_LINK_CHAR_CTRL); `CHK("char reg", RST_WORD, d)
    rd(12'h300); `CHK("unmapped", RESP_SLVERR, r)
    wr(ADDR_LINK_CHAR_CTRL, 32'h0000_7bfb); `CHK("wr resp", RESP_OKAY, r)
    rd(ADDR_LINK_CHAR_CTRL); `CHK("char bits", 32'h0000_1800, d)
  endtask
  task automatic pulse(input logic mask, input bit useTrig, input logic [31:0] exp);
    wr(ADDR_TRIG_RESET_MASK_CTRL, {29'h0, mask, mask, 1'b0});
    n0 = nClk; n1 = nNl;
    if (useTrig) trig <= 1; else sysref <= 1;
    repeat (8) @(posedge clk);
    trig <= 0; sysref <= 0;
    repeat (8) @(posedge clk);
    if (useTrig) `CHK("trig resets", exp, nClk - n0)
    else `CHK("nonlink resets", exp, nNl - n1)
  endtask
  task automatic t_kforce();
    rd(ADDR_LINK_STATUS); `CHK("auto k", AUTO_MF_LENGTH_M1, d[6:2])
    wr(ADDR_FORCED_MF_LENGTH, 32'h7);
    wr(ADDR_LINK_CHAR_CTRL, 32'h4);
    rd(ADDR_LINK_STATUS); `CHK("forced k", 5'h07, d[6:2])
    wr(ADDR_LINK_CHAR_CTRL, 32'h0);
  endtask
  task automatic t_repl(input logic [31:0] v, input int lo7, input int hi7, input bit k3);
    wr(ADDR_LINK_CHAR_CTRL, v);
    n0 = nK7; n1 = nK3;
    repeat (200) @(posedge clk);
    `CHK("k28.7 count ok", 1'b1, (nK7 - n0 >= lo7) && (nK7 - n0 <= hi7))
    `CHK("k28.3 seen", k3, nK3 > n1)
  endtask
  task automatic t_idle();
    int i;
    wr(ADDR_LINK_CHAR_CTRL, 32'h9c00);
    i = 0;
    do @(posedge clk); while (laneOctet !== 8'h50 && ++i < 50);
    for (i = 0; i < 4; i++) begin
      @(posedge clk); `CHK("idle hi", {1'b0, IDLE_PATTERN[15:8]}, {laneIsK, laneOctet})
      @(posedge clk); `CHK("idle lo", {1'b0, IDLE_PATTERN[7:0]}, {laneIsK, laneOctet})
      `CHK("idle no payload", 1'b0, payloadTaken)
    end
  endtask
  task automatic t_dis();
    wr(ADDR_LINK_CHAR_CTRL, 32'h0400);
    resync <= 1;
    repeat (20) @(posedge clk);
    resync <= 0;
    n0 = nK0;
    repeat (300) @(posedge clk);
    `CHK("no ila", 0, nK0 - n0)
    rd(ADDR_LINK_STATUS); `CHK("data state", 2'h2, d[1:0])
    `CHK("payload on", 1'b1, payloadTaken)
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1;
    repeat (300) @(posedge clk);
    `CHK("ila sent", 1'b1, nK0 > 0)
    t_regs();
    pulse(1'b0, 1, 1); pulse(1'b1, 1, 0); pulse(1'b0, 0, 1); pulse(1'b1, 0, 0);
    t_kforce();
    t_repl(32'h0, 0, 0, 0);
    t_repl(32'h0800, 49, 51, 0);
    t_repl(32'h1800, 1, 51, 1);
    // Changing payload: no end octet repeats, so nothing may be replaced
    vary <= 1;
    t_repl(32'h1800, 0, 0, 0);
    vary <= 0;
    t_idle();
    t_dis();
    tally_and_finish();
  end
endmodule
